// File: drive_model.sv
/*
 Gate drive and ADC trigger stand-in for the timing unit outputs.
 Counts sync rising edges and any leg with both switches on.
*/
`timescale 1ns/1ps
module drive_model
(
	// From the timing unit
	input wire logic core_clk,
	input wire logic [5:0] gates,
	input wire logic sync_in,
	// Observed counts
	output int adc_starts,
	output int shorts
);
	logic sync_d = 1'b0;
	int starts_q = 0;
	int shorts_q = 0;
	assign adc_starts = starts_q;
	assign shorts = shorts_q;
	// A shorted leg would wreck the bridge, so every clock with any leg shorted is counted once
	always @(posedge core_clk)
	begin
		sync_d <= sync_in;
		if (sync_in && !sync_d)
			starts_q <= starts_q + 1;
		if ((gates[5] && gates[4]) || (gates[3] && gates[2]) ||
			(gates[1] && gates[0]))
			shorts_q <= shorts_q + 1;
	end
endmodule : drive_model

// File: pwm_chk_properties.sv
/*
 Port checker for the PWM timing unit.
 Bound to the top module from tb_top; sees its ports only.
*/
`timescale 1ns/1ps
module pwm_chk
	import pwm_timing_pkg::*;
(
	// Clock, reset and bus
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic pready,
	input wire logic [11:0] paddr,
	// Outputs
	input wire logic phase_a_high,
	input wire logic phase_a_low,
	input wire logic phase_b_high,
	input wire logic phase_b_low,
	input wire logic phase_c_high,
	input wire logic phase_c_low,
	input wire logic period_sync_pulse,
	input wire logic sync_irq,
	input wire logic [SEG_W-1:0] output_segment_control
);
	logic [3:0] seen;
	wire wr = psel && penable && pwrite && pready;
	wire [3:0] hit = {paddr == OFS_HALF_PERIOD, paddr == OFS_DUTY_A,
		paddr == OFS_DUTY_B, paddr == OFS_DUTY_C};
	wire quiet = !(period_sync_pulse || phase_a_high || phase_a_low ||
		phase_b_high || phase_b_low || phase_c_high || phase_c_low);
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			seen <= 4'h0;
		else if (wr)
			seen <= seen | hit;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	pair_a_excl_a: assert property (!(phase_a_high && phase_a_low))
		else $error("pair a both on");
	pair_b_excl_a: assert property (!(phase_b_high && phase_b_low))
		else $error("pair b both on");
	pair_c_excl_a: assert property (!(phase_c_high && phase_c_low))
		else $error("pair c both on");
	irq_on_sync_a: assert property ($rose(period_sync_pulse) |-> sync_irq)
		else $error("sync without irq");
	irq_cause_a: assert property (sync_irq |-> $rose(period_sync_pulse))
		else $error("irq without sync edge");
	idle_unset_a: assert property (seen != 4'hF |-> quiet)
		else $error("output before setup");
	sync_end_a: assert property ($rose(period_sync_pulse) |->
		##[1:256] !period_sync_pulse) else $error("sync too long");
	seg_at_sync_a: assert property ($changed(output_segment_control)
		|-> ##[0:2] period_sync_pulse) else $error("segment off sync");
	cover property ($rose(period_sync_pulse));
	cover property ($rose(phase_a_low));
	cover property (sync_irq && phase_b_low);
	cover property ($changed(output_segment_control));
endmodule : pwm_chk

// File: pwm_timing_pkg.sv
/*
 Constants for the three-phase centre-based PWM timing unit: register
 offsets, field positions, reset values and widths.
 Assumes an APB slave with 32-bit data, one register per aligned word.
*/
// Behaviour
// - 16-bit counters, three complementary output pairs
// - Mode bit 6: zero single, one double
// - Reset clears mode bit: single update
// - One clock per unit; period twice half-period
// - Half-period register 16 bits, any value
// - Dead time 10 bits, two units per step
// - Dead time between complementary turn-on edges
// - Dead time zero inserts no delay
// - Single mode: sync per period loads registers
// - Sync edge also loads output segment control
// - Double mode: extra midpoint sync, reload
// - Status bit 3 marks second half; the code sets it in double mode only and keeps it zero in single mode
// - Sync width is register plus one
// - Sync-width resets to 0x27
// - Sync pulse output for ADC alignment
// - Three 16-bit duty registers
// - Duty sets high-side on-time per half
// - Minimum on-time equals minimum-pulse register
// - No outputs until period and duties written
// - Interrupt request on every sync pulse
package pwm_timing_pkg;
	localparam logic [11:0] OFS_HALF_PERIOD = 12'h000;
	localparam logic [11:0] OFS_DEAD_TIME = 12'h004;
	localparam logic [11:0] OFS_MIN_PULSE = 12'h008;
	localparam logic [11:0] OFS_SYNC_WIDTH = 12'h00C;
	localparam logic [11:0] OFS_DUTY_A = 12'h010;
	localparam logic [11:0] OFS_DUTY_B = 12'h014;
	localparam logic [11:0] OFS_DUTY_C = 12'h018;
	localparam logic [11:0] OFS_SEGMENT = 12'h01C;
	localparam logic [11:0] OFS_MODE = 12'h020;
	localparam logic [11:0] OFS_STATUS = 12'h024;
	localparam int MODE_DOUBLE_BIT = 6;
	localparam int STATUS_HALF_BIT = 3;
	localparam int STATUS_RUN_BIT = 0;
	localparam int DEAD_W = 10;
	localparam int SYNC_W = 8;
	localparam int SEG_W = 9;
	localparam logic [7:0] SYNC_WIDTH_RESET = 8'h27;
	localparam logic [15:0] HALF_PERIOD_RESET = 16'h0000;
	localparam logic [15:0] DUTY_RESET = 16'h0000;
	localparam logic [9:0] DEAD_TIME_RESET = 10'h000;
	localparam logic [15:0] MIN_PULSE_RESET = 16'h0000;
	localparam logic [8:0] SEGMENT_RESET = 9'h000;
endpackage : pwm_timing_pkg

// File: tb_top.sv
/*
 Self-checking bench for the PWM timing unit: APB master, register
 model and period measurement. Assumes checker and drive model files.
*/
`timescale 1ns/1ps
module tb_top
	import pwm_timing_pkg::*;
();
	logic core_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, er;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, rd, w, s;
	wire logic [31:0] prdata;
	wire logic pready, pslverr, sync, irq;
	wire logic [5:0] g;
	wire logic [8:0] seg;
	int fail_count = 0, n_checks = 0, adc, shorts, i, r, a0, H, sw, dt;
	int d[3], cnt[8];
	logic [31:0] msk[9] = '{32'h0000_FFFF, 32'h0000_03FF, 32'h0000_FFFF,
		32'h0000_00FF, 32'h0000_FFFF, 32'h0000_FFFF, 32'h0000_FFFF,
		32'h0000_01FF, 32'h0000_0040};
	always #10 core_clk = ~core_clk;
	three_phase_pwm_timing_unit dut_u (.core_clk, .nrst, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.phase_a_high(g[5]), .phase_a_low(g[4]), .phase_b_high(g[3]),
		.phase_b_low(g[2]), .phase_c_high(g[1]), .phase_c_low(g[0]),
		.period_sync_pulse(sync), .sync_irq(irq),
		.output_segment_control(seg));
	drive_model far_u (.core_clk, .gates(g), .sync_in(sync),
		.adc_starts(adc), .shorts);
	task automatic test_done;
	begin
		$display("checks=%0d errors=%0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	end
	endtask : test_done
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
	begin
		n_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	end
	endtask : chk
	task automatic apb(input logic wn, input logic [11:0] a,
		input logic [31:0] v);
		int k;
	begin
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= wn;
		paddr <= a;
		pwdata <= v;
		@(posedge core_clk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge core_clk);
			k++;
		end
		while (pready !== 1'b1 && k < 50);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 50)
		begin
			fail_count++;
			test_done();
		end
	end
	endtask : apb
	// Sync rise to next sync rise; the bound also catches a dead counter
	task automatic measure;
		int k;
	begin
		for (k = 0; k < 300 && sync !== 1'b0; k++)
			@(posedge core_clk);
		for (k = 0; k < 300 && sync !== 1'b1; k++)
			@(posedge core_clk);
		cnt = '{default: 0};
		a0 = adc;
		do
		begin
			for (k = 0; k < 6; k++)
				cnt[k] += int'(g[k]);
			cnt[6] += int'(sync);
			cnt[7]++;
			@(posedge core_clk);
		end
		while (!(sync === 1'b1 && cnt[6] < cnt[7]) && cnt[7] < 300);
		chk(adc - a0, 1);
		if (cnt[7] >= 300)
		begin
			fail_count++;
			test_done();
		end
	end
	endtask : measure
	initial
	begin
		void'($urandom(32'h0000_068E));
		repeat (20) @(posedge core_clk);
		nrst <= 1'b1;
		for (i = 0; i < 9; i++)
		begin
			w = $urandom;
			apb(1'b1, 12'(i * 4), w);
			apb(1'b0, 12'(i * 4), 32'h0000_0000);
			chk(rd, w & msk[i]);
		end
		apb(1'b1, 12'h0FC, 32'hFFFF_FFFF);
		chk(32'(er), 32'h0000_0001);
		@(posedge core_clk);
		nrst <= 1'b0;
		@(posedge core_clk);
		nrst <= 1'b1;
		for (i = 0; i < 9; i++)
		begin
			apb(1'b0, 12'(i * 4), 32'h0000_0000);
			chk(rd, (i == 3) ? 32'h0000_0027 : 32'h0000_0000);
		end
		H = 40;
		sw = 3;
		d[0] = 10;
		d[2] = 20;
		apb(1'b1, OFS_SYNC_WIDTH, 32'(sw));
		apb(1'b1, OFS_DUTY_A, 32'(d[0]));
		apb(1'b1, OFS_DUTY_C, 32'(d[2]));
		apb(1'b1, OFS_HALF_PERIOD, 32'(H));
		for (r = 0; r < 3; r++)
		begin
			dt = (r == 1) ? 0 : 2;
			d[1] = 3 + int'($urandom % 30);
			apb(1'b1, OFS_DEAD_TIME, 32'(dt));
			apb(1'b1, OFS_DUTY_B, 32'(d[1]));
			w = $urandom & 32'h0000_01FF;
			apb(1'b1, OFS_SEGMENT, w);
			if (r == 2)
				apb(1'b1, OFS_MODE, 32'h0000_0040);
			measure();
			measure();
			apb(1'b0, OFS_STATUS, 32'h0000_0000);
			s = rd;
			measure();
			apb(1'b0, OFS_STATUS, 32'h0000_0000);
			chk(32'(cnt[6]), 32'(sw + 1));
			chk(32'(seg), w);
			if (r < 2)
			begin
				chk(rd & 32'h0000_0008, 32'h0000_0000);
				chk(32'(cnt[7]), 32'(2 * H));
				for (i = 0; i < 3; i++)
				begin
					chk(32'(cnt[5 - 2 * i]), 32'(2 * (d[i] - dt)));
					chk(32'(cnt[4 - 2 * i]), 32'(2 * (H - d[i] - dt)));
				end
			end
			else
			begin
				chk(32'(cnt[7]), 32'(H));
				// Two halves apart: same half; one more half flips it
				chk((s ^ rd) & 32'h0000_0008, 32'h0000_0000);
				repeat (H) @(posedge core_clk);
				apb(1'b0, OFS_STATUS, 32'h0000_0000);
				chk((s ^ rd) & 32'h0000_0008, 32'h0000_0008);
			end
		end
		chk(32'(shorts), 32'h0000_0000);
		test_done();
	end
endmodule : tb_top
bind three_phase_pwm_timing_unit pwm_chk chk_u (.core_clk, .nrst, .psel,
	.penable, .pwrite, .pready, .paddr, .phase_a_high, .phase_a_low,
	.phase_b_high, .phase_b_low, .phase_c_high, .phase_c_low,
	.period_sync_pulse, .sync_irq, .output_segment_control);

// File: three_phase_pwm_timing_unit.sv
/*
 Three-phase centre-based PWM timing unit with APB register access.
 Assumes core_clk is the instruction clock; outputs feed the output
 control unit, ADC sync and an interrupt controller outside.
*/
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module three_phase_pwm_timing_unit
	import pwm_timing_pkg::*;
#(
	parameter int CNT_W = 16
)
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pulse pairs
	output logic phase_a_high,
	output logic phase_a_low,
	output logic phase_b_high,
	output logic phase_b_low,
	output logic phase_c_high,
	output logic phase_c_low,
	// Sync, interrupt and latched segment control
	output logic period_sync_pulse,
	output logic sync_irq,
	output logic [SEG_W-1:0] output_segment_control
);
	initial
	begin
		if (CNT_W != 16)
			$error("CNT_W must be 16");
	end

	typedef enum logic {DIR_UP, DIR_DOWN} dir_t;

	// Software-side registers
	logic [15:0] half_period_count;
	logic [DEAD_W-1:0] dead_time_count;
	logic [15:0] min_pulse_count;
	logic [SYNC_W-1:0] sync_width_count;
	logic [15:0] duty_phase_a;
	logic [15:0] duty_phase_b;
	logic [15:0] duty_phase_c;
	logic [SEG_W-1:0] segment_reg;
	logic mode_double;
	logic [3:0] written;

	// Latched working copies
	logic [15:0] act_half;
	logic [DEAD_W-1:0] act_dead;
	logic [15:0] act_min;
	logic [15:0] act_duty [3];

	logic running;
	logic [15:0] count;
	dir_t dir;
	logic second_half;
	logic [SYNC_W:0] sync_cnt;

	wire access_w = psel && penable;
	wire wr_en = access_w && pwrite;
	wire hit_hp = paddr == OFS_HALF_PERIOD;
	wire hit_dt = paddr == OFS_DEAD_TIME;
	wire hit_pd = paddr == OFS_MIN_PULSE;
	wire hit_sw = paddr == OFS_SYNC_WIDTH;
	wire hit_da = paddr == OFS_DUTY_A;
	wire hit_db = paddr == OFS_DUTY_B;
	wire hit_dc = paddr == OFS_DUTY_C;
	wire hit_sg = paddr == OFS_SEGMENT;
	wire hit_md = paddr == OFS_MODE;
	wire hit_st = paddr == OFS_STATUS;
	wire hit_any = hit_hp | hit_dt | hit_pd | hit_sw | hit_da | hit_db |
		hit_dc | hit_sg | hit_md | hit_st;
	wire all_written = &written;

	// Counter ends: turn at the top, period ends at zero
	wire at_top = dir == DIR_UP && count >= act_half - 16'h0001;
	wire at_bottom = dir == DIR_DOWN && count <= 16'h0001;
	wire start_run = !running && all_written;
	wire period_start = start_run || (running && at_bottom);
	wire mid_point = running && at_top;
	wire sync_event = period_start || (mid_point && mode_double);
	// Any latch point reloads the working copies
	wire load_event = period_start || (mid_point && mode_double);
	// Slope as a level for the pair generators
	wire counting_down = dir == DIR_DOWN;

	assign pready = 1'b1;
	assign pslverr = access_w && !hit_any;

	// Register writes
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			half_period_count <= HALF_PERIOD_RESET;
			dead_time_count <= DEAD_TIME_RESET;
			min_pulse_count <= MIN_PULSE_RESET;
			sync_width_count <= SYNC_WIDTH_RESET;
			duty_phase_a <= DUTY_RESET;
			duty_phase_b <= DUTY_RESET;
			duty_phase_c <= DUTY_RESET;
			segment_reg <= SEGMENT_RESET;
			mode_double <= 1'b0;
			written <= 4'h0;
		end
		else if (wr_en)
		begin
			if (hit_hp)
				half_period_count <= pwdata[15:0];
			if (hit_dt)
				dead_time_count <= pwdata[DEAD_W-1:0];
			if (hit_pd)
				min_pulse_count <= pwdata[15:0];
			if (hit_sw)
				sync_width_count <= pwdata[SYNC_W-1:0];
			if (hit_da)
				duty_phase_a <= pwdata[15:0];
			if (hit_db)
				duty_phase_b <= pwdata[15:0];
			if (hit_dc)
				duty_phase_c <= pwdata[15:0];
			if (hit_sg)
				segment_reg <= pwdata[SEG_W-1:0];
			if (hit_md)
				mode_double <= pwdata[MODE_DOUBLE_BIT];
			written <= written | {hit_dc, hit_db, hit_da, hit_hp};
		end
	end

	// Read mux
	always_comb
	begin
		prdata = 32'h0000_0000;
		if (access_w && !pwrite)
		begin
			if (hit_hp)
				prdata[15:0] = half_period_count;
			if (hit_dt)
				prdata[DEAD_W-1:0] = dead_time_count;
			if (hit_pd)
				prdata[15:0] = min_pulse_count;
			if (hit_sw)
				prdata[SYNC_W-1:0] = sync_width_count;
			if (hit_da)
				prdata[15:0] = duty_phase_a;
			if (hit_db)
				prdata[15:0] = duty_phase_b;
			if (hit_dc)
				prdata[15:0] = duty_phase_c;
			if (hit_sg)
				prdata[SEG_W-1:0] = segment_reg;
			if (hit_md)
				prdata[MODE_DOUBLE_BIT] = mode_double;
			if (hit_st)
			begin
				prdata[STATUS_HALF_BIT] = second_half;
				prdata[STATUS_RUN_BIT] = running;
			end
		end
	end

	// Latch working copies on each sync rising edge
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			act_half <= HALF_PERIOD_RESET;
			act_dead <= DEAD_TIME_RESET;
			act_min <= MIN_PULSE_RESET;
			act_duty[0] <= DUTY_RESET;
			act_duty[1] <= DUTY_RESET;
			act_duty[2] <= DUTY_RESET;
			output_segment_control <= SEGMENT_RESET;
		end
		else if (load_event)
		begin
			act_half <= half_period_count;
			act_dead <= dead_time_count;
			act_min <= min_pulse_count;
			act_duty[0] <= duty_phase_a;
			act_duty[1] <= duty_phase_b;
			act_duty[2] <= duty_phase_c;
			output_segment_control <= segment_reg;
		end
	end

	// Up/down period counter, one step per clock
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			running <= 1'b0;
			count <= 16'h0000;
			dir <= DIR_UP;
			second_half <= 1'b0;
		end
		else if (start_run)
		begin
			running <= 1'b1;
			count <= 16'h0000;
			dir <= DIR_UP;
			second_half <= 1'b0;
		end
		else if (running)
		begin
			if (at_top)
			begin
				dir <= DIR_DOWN;
				count <= act_half;
				second_half <= mode_double;
			end
			else if (at_bottom)
			begin
				dir <= DIR_UP;
				count <= 16'h0000;
				second_half <= 1'b0;
			end
			else if (dir == DIR_UP)
				count <= count + 16'h0001;
			else
				count <= count - 16'h0001;
		end
	end

	// Sync pulse: width is register plus one clocks
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			sync_cnt <= '0;
			period_sync_pulse <= 1'b0;
			sync_irq <= 1'b0;
		end
		else
		begin
			sync_irq <= sync_event;
			if (sync_event)
			begin
				period_sync_pulse <= 1'b1;
				// Same value a latch would take at this edge
				sync_cnt <= {1'b0, sync_width_count};
			end
			else if (sync_cnt != '0)
				sync_cnt <= sync_cnt - 1'b1;
			else
				period_sync_pulse <= 1'b0;
		end
	end

	// One pair generator per phase, all fed the same counter
	phase_pair_gen #(.CW(CNT_W), .DW(DEAD_W)) pair_a_u (
		.core_clk,
		.nrst,
		.running,
		.count_down(counting_down),
		.count,
		.half(act_half),
		.duty(act_duty[0]),
		.min_on(act_min),
		.dead(act_dead),
		.high_on(phase_a_high),
		.low_on(phase_a_low)
	);

	phase_pair_gen #(.CW(CNT_W), .DW(DEAD_W)) pair_b_u (
		.core_clk,
		.nrst,
		.running,
		.count_down(counting_down),
		.count,
		.half(act_half),
		.duty(act_duty[1]),
		.min_on(act_min),
		.dead(act_dead),
		.high_on(phase_b_high),
		.low_on(phase_b_low)
	);

	phase_pair_gen #(.CW(CNT_W), .DW(DEAD_W)) pair_c_u (
		.core_clk,
		.nrst,
		.running,
		.count_down(counting_down),
		.count,
		.half(act_half),
		.duty(act_duty[2]),
		.min_on(act_min),
		.dead(act_dead),
		.high_on(phase_c_high),
		.low_on(phase_c_low)
	);
endmodule : three_phase_pwm_timing_unit

// One complementary pair: centre compare, narrow pulses, dead time
module phase_pair_gen
	import pwm_timing_pkg::*;
#(
	parameter int CW = 16,
	parameter int DW = 10
)
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// Period counter state
	input wire logic running,
	input wire logic count_down,
	input wire logic [CW-1:0] count,
	// Latched working copies
	input wire logic [CW-1:0] half,
	input wire logic [CW-1:0] duty,
	input wire logic [CW-1:0] min_on,
	input wire logic [DW-1:0] dead,
	// Pulse pair
	output logic high_on,
	output logic low_on
);
	initial
	begin
		if (CW < 2 || DW < 1)
			$error("phase_pair_gen widths out of range");
	end

	logic raw_q;
	logic [DW:0] dt_cnt;

	// Centre count shows once, on the way down: strict compare there
	// gives exactly duty counts on each slope
	wire [CW:0] duty_w = {1'b0, duty};
	wire [CW:0] from_ctr = {1'b0, half} - {1'b0, count};
	wire in_window = count_down ? from_ctr < duty_w : from_ctr <= duty_w;
	wire raw_on = running && in_window;
	// Pulses shorter than the minimum are dropped entirely
	wire [CW:0] lo_time = {1'b0, half} - duty_w;
	wire hi_ok = duty_w >= {1'b0, min_on};
	wire lo_ok = lo_time >= {1'b0, min_on};
	wire demand = raw_on ? hi_ok : !lo_ok;
	wire [DW:0] dt_full = {dead, 1'b0};
	wire dt_zero = dt_full == '0;
	wire dt_done = dt_cnt <= {{DW{1'b0}}, 1'b1};

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			raw_q <= 1'b0;
			dt_cnt <= '0;
			high_on <= 1'b0;
			low_on <= 1'b0;
		end
		else if (!running)
		begin
			raw_q <= 1'b0;
			dt_cnt <= '0;
			high_on <= 1'b0;
			low_on <= 1'b0;
		end
		else if (demand != raw_q)
		begin
			raw_q <= demand;
			dt_cnt <= dt_full;
			high_on <= dt_zero && demand;
			low_on <= dt_zero && !demand;
		end
		else if (!dt_done)
			dt_cnt <= dt_cnt - 1'b1;
		else
		begin
			dt_cnt <= '0;
			high_on <= raw_q;
			low_on <= !raw_q;
		end
	end
endmodule : phase_pair_gen
